// >>> design/debug_serial_uart_pkg.sv
package debug_serial_uart_pkg;

  // register word addresses on the processor data bus
  localparam logic [15:0] ADDR_LINE_STATE = 16'hC028;
  localparam logic [15:0] ADDR_BYTE_LOW = 16'hC029;
  localparam logic [15:0] ADDR_BYTE_HIGH = 16'hC02A;
  localparam logic [15:0] ADDR_BAUD_DIV = 16'hC02B;

  // serial_line_state bit positions
  localparam int ST_OVERRUN_BIT = 3;
  localparam int ST_RX_FULL_BIT = 2;
  localparam int ST_TX_FULL_BIT = 1;
  localparam int ST_TX_ACTIVE_BIT = 0;

  // baud_rate_divisors fields
  localparam int PRESCALE_LSB = 8;
  localparam int BIT_TIME_LSB = 0;
  localparam int DIV_FIELD_W = 8;

  // reset values
  localparam logic [15:0] BAUD_DIV_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] RDATA_RESET = 16'h0000;

  // frame shape: start, eight data bits, stop
  localparam int DATA_BITS = 8;
  localparam int FRAME_BITS = 10;
  localparam logic [3:0] LAST_FRAME_BIT = 4'h9;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;

  typedef struct packed {
    logic [15:0] addr;  // word address
    logic wr;           // one-cycle write strobe
    logic rd;           // one-cycle read strobe
    logic [15:0] wdata; // write data
  } reg_req_t;

  typedef struct packed {
    logic overrun;
    logic rx_full;
    logic tx_full;
    logic tx_active;
  } line_state_t;

  typedef struct packed {
    logic valid;       // one-cycle pulse per good frame
    logic [7:0] data;  // received byte
  } rx_byte_t;

  // true on the last prescale tick of one bit time
  function automatic logic bit_time_done(input logic [7:0] cnt, input logic [7:0] limit);
    return ({1'b0, cnt} + 9'h001) >= {1'b0, limit};
  endfunction

endpackage

// >>> design/baud_prescaler.sv
`timescale 1ns/1ps
module baud_prescaler (
  input wire logic core_clk_in,          // master clock
  input wire logic reset_in,             // synchronous reset, active high
  input wire logic [7:0] prescale_in,    // prescale_divisor field
  output logic tick_out                  // one pulse every prescale+1 cycles
);
  logic [7:0] cnt_r;

  // intermediate clock: the receiver sampling rate and bit counter base
  assign tick_out = (cnt_r >= prescale_in);

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      cnt_r <= 8'h00;
    end else if (tick_out) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule // baud_prescaler

// >>> design/serial_receiver.sv
`timescale 1ns/1ps
module serial_receiver (
  input wire logic core_clk_in,                        // master clock
  input wire logic reset_in,                           // synchronous reset
  input wire logic tick_in,                            // sampling tick
  input wire logic line_in,                            // synchronised rx line
  input wire logic [7:0] bit_time_in,                  // ticks per bit
  output debug_serial_uart_pkg::rx_byte_t rx_byte_out  // good frame result
);
  import debug_serial_uart_pkg::*;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

  rx_state_t state_r;
  logic prev_r;
  logic [7:0] cnt_r;
  logic [2:0] idx_r;
  logic [7:0] shift_r;
  logic [7:0] half_time;

  assign half_time = {1'b0, bit_time_in[7:1]};

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_r <= RX_IDLE;
      prev_r <= 1'b1;
      cnt_r <= 8'h00;
      idx_r <= 3'h0;
      shift_r <= BYTE_RESET;
      rx_byte_out <= '0;
    end else begin
      rx_byte_out.valid <= 1'b0;
      if (tick_in) begin
        unique case (state_r)
          RX_IDLE: begin
            prev_r <= line_in;
            cnt_r <= 8'h00;
            if (prev_r && !line_in) begin  // see [R12]
              state_r <= RX_START;
            end
          end
          RX_START: begin
            // mid start bit: a glitch that is high again is not a frame
            if (bit_time_done(cnt_r, half_time)) begin
              cnt_r <= 8'h00;
              idx_r <= 3'h0;
              state_r <= line_in ? RX_IDLE : RX_DATA;
              prev_r <= line_in;
            end else begin
              cnt_r <= cnt_r + 8'h01;
            end
          end
          RX_DATA: begin
            if (bit_time_done(cnt_r, bit_time_in)) begin
              cnt_r <= 8'h00;
              shift_r <= {line_in, shift_r[7:1]};  // see [R12]
              idx_r <= idx_r + 3'h1;
              if (idx_r == LAST_DATA_BIT) begin
                state_r <= RX_STOP;
              end
            end else begin
              cnt_r <= cnt_r + 8'h01;
            end
          end
          RX_STOP: begin
            if (bit_time_done(cnt_r, bit_time_in)) begin
              cnt_r <= 8'h00;
              prev_r <= line_in;
              state_r <= RX_IDLE;
              // low stop bit: frame dropped silently
              if (line_in) begin  // see [R13] see [R19]
                rx_byte_out.valid <= 1'b1;
                rx_byte_out.data <= shift_r;
              end
            end else begin
              cnt_r <= cnt_r + 8'h01;
            end
          end
        endcase
      end
    end
  end

  AST_BAD_STOP_NO_BYTE: assert property (@(posedge core_clk_in) disable iff (reset_in)  // see [R19]
    state_r == RX_STOP && tick_in && bit_time_done(cnt_r, bit_time_in) && !line_in
      |=> !rx_byte_out.valid)
    else $error("frame with low stop bit was delivered");
endmodule // serial_receiver

// >>> design/debug_serial_uart.sv
`timescale 1ns/1ps
// Functional notes
// [R1] idle line high; frame is low start, eight bits LSB first, high stop.
// [R2] status: bit3 overrun, bit2 rx full, bit1 tx full, bit0 tx active.
// [R3] tx full flag high while holding register still holds an unsent byte.
// [R4] tx active flag high while the shift register sends a frame.
// [R5] low data read returns byte on 7:0, zeros above, clears rx full.
// [R6] low data write queues only bits 7:0 for sending.
// [R7] write when idle loads shifter at once, starts frame, raises tx interrupt.
// [R8] write when busy sets tx full; byte waits for end of frame.
// [R9] holding register empties the moment its byte starts shifting.
// [R10] software writes only when tx full is clear; one per tx interrupt.
// [R11] high data register behaves the same but uses bits 15:8.
// [R12] receiver finds start on falling edge, samples eight bits mid-bit.
// [R13] good stop bit: store byte, rx interrupt, overrun takes old full, set full.
// [R14] divider holds prescale in bits 15:8 and bit time in bits 7:0.
// [R15] bit rate is master clock over (prescale plus one) times bit time.
// [R16] receiver samples on the prescaled intermediate clock.
// [R17] divider resets to zero; firmware programs it afterwards.
// [R18] software keeps bit time divisor between 6 and 255.
// [R19] low stop bit drops the frame with no status change or interrupt.
module debug_serial_uart (
  input wire logic core_clk_in,                        // master clock
  input wire logic reset_in,                           // synchronous reset, active high
  input debug_serial_uart_pkg::reg_req_t reg_req_in,   // processor register access
  output logic [15:0] reg_rdata_out,                   // read data, one cycle after rd
  input wire logic serial_rx_in,                       // serial receive pin
  output logic serial_tx_out,                          // serial transmit pin
  output logic transmit_start_irq_out,                 // pulse when a frame starts
  output logic receive_done_irq_out                    // pulse when a byte arrives
);
  import debug_serial_uart_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  logic [15:0] baud_div_r;
  logic [7:0] prescale_divisor;
  logic [7:0] bit_time_divisor;
  logic wr_low;
  logic wr_high;
  logic wr_data;
  logic wr_div;
  logic rd_low;
  logic rd_high;
  logic rd_data;
  logic rd_state;
  logic [7:0] wr_byte;

  assign wr_low = reg_req_in.wr && (reg_req_in.addr == ADDR_BYTE_LOW);
  assign wr_high = reg_req_in.wr && (reg_req_in.addr == ADDR_BYTE_HIGH);
  assign wr_div = reg_req_in.wr && (reg_req_in.addr == ADDR_BAUD_DIV);
  assign wr_data = wr_low || wr_high;
  assign rd_low = reg_req_in.rd && (reg_req_in.addr == ADDR_BYTE_LOW);
  assign rd_high = reg_req_in.rd && (reg_req_in.addr == ADDR_BYTE_HIGH);
  assign rd_state = reg_req_in.rd && (reg_req_in.addr == ADDR_LINE_STATE);
  assign rd_data = rd_low || rd_high;

  // only the selected byte lane is taken, the rest of the word is ignored
  assign wr_byte = wr_high ? reg_req_in.wdata[15:8] : reg_req_in.wdata[7:0];  // see [R6] see [R11]

  assign prescale_divisor = baud_div_r[PRESCALE_LSB +: DIV_FIELD_W];  // see [R14]
  assign bit_time_divisor = baud_div_r[BIT_TIME_LSB +: DIV_FIELD_W];  // see [R14]

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      baud_div_r <= BAUD_DIV_RESET;  // see [R17]
    end else if (wr_div) begin
      baud_div_r <= reg_req_in.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit clock and receiver input

  logic tick;
  logic rx_meta_r;
  logic rx_sync_r;
  rx_byte_t rx_byte;

  // one prescaler shared by both directions; bit time counted in ticks
  baud_prescaler u_prescaler (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .prescale_in(prescale_divisor),
    .tick_out(tick)
  );  // see [R15]

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end else begin
      rx_meta_r <= serial_rx_in;
      rx_sync_r <= rx_meta_r;
    end
  end

  // receiver runs on the prescaled tick, not on the bit clock
  serial_receiver u_receiver (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .tick_in(tick),
    .line_in(rx_sync_r),
    .bit_time_in(bit_time_divisor),
    .rx_byte_out(rx_byte)
  );  // see [R16]

  ////////////////////////////////////////////////////////////////////////////
  // transmitter

  logic [7:0] tx_hold_r;
  logic tx_hold_full_r;
  logic tx_active_r;
  logic [8:0] tx_shift_r;
  logic [3:0] tx_bit_r;
  logic [7:0] tx_cnt_r;
  logic tx_line_r;
  logic tx_irq_r;
  logic bit_end;
  logic frame_end;
  logic load_direct;
  logic load_queued;
  logic load_shifter;
  logic [7:0] load_byte;

  assign bit_end = tx_active_r && tick && bit_time_done(tx_cnt_r, bit_time_divisor);
  assign frame_end = bit_end && (tx_bit_r == LAST_FRAME_BIT);
  // an idle transmitter takes the write at once; so does one whose stop bit ends now,
  // else the byte would sit in the holding register with nothing left to move it
  assign load_direct = wr_data && !tx_hold_full_r && (!tx_active_r || frame_end);  // see [R7]
  // a waiting byte follows the stop bit without a gap
  assign load_queued = frame_end && tx_hold_full_r;  // see [R8]
  assign load_shifter = load_direct || load_queued;
  assign load_byte = load_direct ? wr_byte : tx_hold_r;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      tx_hold_r <= BYTE_RESET;
      tx_hold_full_r <= 1'b0;
    end else if (wr_data && !load_direct) begin
      // writing while full overwrites; software must avoid it
      tx_hold_r <= wr_byte;  // see [R10]
      tx_hold_full_r <= 1'b1;  // see [R3] see [R8]
    end else if (load_queued) begin
      tx_hold_full_r <= 1'b0;  // see [R9]
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      tx_active_r <= 1'b0;
      tx_shift_r <= 9'h1FF;
      tx_bit_r <= 4'h0;
      tx_cnt_r <= 8'h00;
      tx_line_r <= 1'b1;
    end else if (load_shifter) begin
      tx_active_r <= 1'b1;  // see [R4]
      tx_shift_r <= {1'b1, load_byte};
      tx_bit_r <= 4'h0;
      tx_cnt_r <= 8'h00;
      tx_line_r <= 1'b0;  // see [R1]
    end else if (frame_end) begin
      tx_active_r <= 1'b0;  // see [R4]
      tx_line_r <= 1'b1;  // see [R1]
    end else if (bit_end) begin
      tx_cnt_r <= 8'h00;
      tx_bit_r <= tx_bit_r + 4'h1;
      tx_line_r <= tx_shift_r[0];  // see [R1]
      tx_shift_r <= {1'b1, tx_shift_r[8:1]};
    end else if (tx_active_r && tick) begin
      tx_cnt_r <= tx_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      tx_irq_r <= 1'b0;
    end else begin
      tx_irq_r <= load_shifter;  // see [R7]
    end
  end

  assign serial_tx_out = tx_line_r;
  assign transmit_start_irq_out = tx_irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // receive data and status

  logic [7:0] rx_data_r;
  logic rx_full_r;
  logic overrun_r;
  logic rx_irq_r;
  line_state_t line_state;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rx_data_r <= BYTE_RESET;
      rx_full_r <= 1'b0;
      overrun_r <= 1'b0;
    end else if (rx_byte.valid) begin
      // new byte wins over a read in the same cycle
      rx_data_r <= rx_byte.data;  // see [R13]
      overrun_r <= rx_full_r;  // see [R13]
      rx_full_r <= 1'b1;
    end else if (rd_data) begin
      rx_full_r <= 1'b0;  // see [R5]
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rx_irq_r <= 1'b0;
    end else begin
      rx_irq_r <= rx_byte.valid;  // see [R13]
    end
  end

  assign receive_done_irq_out = rx_irq_r;

  assign line_state.overrun = overrun_r;
  assign line_state.rx_full = rx_full_r;
  assign line_state.tx_full = tx_hold_full_r;
  assign line_state.tx_active = tx_active_r;

  ////////////////////////////////////////////////////////////////////////////
  // read data

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      reg_rdata_out <= RDATA_RESET;
    end else if (rd_state) begin
      reg_rdata_out <= {12'h000, line_state};  // see [R2]
    end else if (rd_low) begin
      reg_rdata_out <= {8'h00, rx_data_r};  // see [R5]
    end else if (rd_high) begin
      reg_rdata_out <= {rx_data_r, 8'h00};  // see [R11]
    end else if (reg_req_in.rd && (reg_req_in.addr == ADDR_BAUD_DIV)) begin
      reg_rdata_out <= baud_div_r;
    end else if (reg_req_in.rd) begin
      reg_rdata_out <= RDATA_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_IDLE_LINE_HIGH: assert property (@(posedge core_clk_in) disable iff (reset_in)  // see [R1]
    !tx_active_r |-> serial_tx_out)
    else $error("tx line low while transmitter idle");

  AST_START_BIT_LOW: assert property (@(posedge core_clk_in) disable iff (reset_in)  // see [R1]
    $rose(tx_active_r) |-> !serial_tx_out && !$past(tx_active_r))
    else $error("frame did not open with a low start bit");

  AST_STATUS_LAYOUT: assert property (@(posedge core_clk_in) disable iff (reset_in)  // see [R2]
    rd_state |=> reg_rdata_out == {12'h000, $past(overrun_r), $past(rx_full_r),
      $past(tx_hold_full_r), $past(tx_active_r)})
    else $error("status read does not match internal flags");

  AST_BUSY_WRITE_QUEUES: assert property (@(posedge core_clk_in) disable iff (reset_in)  // see [R8]
    wr_data && tx_active_r && !frame_end |=> tx_hold_full_r && tx_active_r)
    else $error("write during frame not held");

  AST_IDLE_WRITE_STARTS: assert property (@(posedge core_clk_in) disable iff (reset_in)  // see [R7]
    wr_data && !tx_active_r && !tx_hold_full_r
      |=> tx_active_r && !tx_hold_full_r && transmit_start_irq_out)
    else $error("idle write did not start frame and interrupt");

  AST_QUEUED_BYTE_FOLLOWS: assert property (@(posedge core_clk_in) disable iff (reset_in)  // see [R9]
    frame_end && tx_hold_full_r && !wr_data
      |=> !tx_hold_full_r && tx_active_r && tx_shift_r[7:0] == $past(tx_hold_r))
    else $error("held byte not moved into shifter at frame end");

  AST_LOW_BYTE_ONLY: assert property (@(posedge core_clk_in) disable iff (reset_in)  // see [R6]
    wr_low && !tx_active_r && !tx_hold_full_r
      |=> tx_shift_r[7:0] == $past(reg_req_in.wdata[7:0]))
    else $error("low lane write took wrong bits");

  AST_HIGH_BYTE_LANE: assert property (@(posedge core_clk_in) disable iff (reset_in)  // see [R11]
    wr_high && !tx_active_r && !tx_hold_full_r
      |=> tx_shift_r[7:0] == $past(reg_req_in.wdata[15:8]))
    else $error("high lane write took wrong bits");

  AST_LOW_READ_ZERO_TOP: assert property (@(posedge core_clk_in) disable iff (reset_in)  // see [R5]
    rd_low |=> reg_rdata_out[15:8] == 8'h00 && reg_rdata_out[7:0] == $past(rx_data_r))
    else $error("low data read returned wrong value");

  AST_READ_CLEARS_FULL: assert property (@(posedge core_clk_in) disable iff (reset_in)  // see [R5]
    rd_data && !rx_byte.valid |=> !rx_full_r)
    else $error("data read did not clear rx full");

  AST_RX_STORE: assert property (@(posedge core_clk_in) disable iff (reset_in)  // see [R13]
    rx_byte.valid |=> rx_full_r && overrun_r == $past(rx_full_r)
      && rx_data_r == $past(rx_byte.data) && receive_done_irq_out)
    else $error("received byte not stored with overrun and interrupt");

  AST_TX_ACTIVE_HOLDS: assert property (@(posedge core_clk_in) disable iff (reset_in)  // see [R4]
    tx_active_r && !frame_end |=> tx_active_r)
    else $error("transmitter active dropped mid frame");

  // a held byte with the shifter stopped would never be sent
  AST_HOLD_NEEDS_ACTIVE: assert property (@(posedge core_clk_in) disable iff (reset_in)  // see [R3]
    tx_hold_full_r |-> tx_active_r)
    else $error("held byte stranded with transmitter idle");

  AST_START_IRQ_WITH_FRAME: assert property (@(posedge core_clk_in) disable iff (reset_in)  // see [R7]
    $rose(tx_active_r) |-> transmit_start_irq_out)
    else $error("frame started without transmit interrupt");

  AST_HIGH_READ_LANE: assert property (@(posedge core_clk_in) disable iff (reset_in)  // see [R11]
    rd_high |=> reg_rdata_out == {$past(rx_data_r), 8'h00})
    else $error("high data read returned wrong value");

  AST_OVERRUN_ONLY_ON_BYTE: assert property (@(posedge core_clk_in) disable iff (reset_in)  // see [R13]
    !rx_byte.valid |=> $stable(overrun_r))
    else $error("overrun changed without a new byte");

  AST_RX_IRQ_ONE_CYCLE: assert property (@(posedge core_clk_in) disable iff (reset_in)  // see [R13]
    receive_done_irq_out |=> !receive_done_irq_out)
    else $error("receive interrupt longer than one cycle");

  AST_LINE_HOLDS_IN_BIT: assert property (@(posedge core_clk_in) disable iff (reset_in)  // see [R15]
    tx_active_r && !bit_end |=> $stable(serial_tx_out))
    else $error("tx line changed inside a bit time");

  AST_DIVIDER_WRITE: assert property (@(posedge core_clk_in) disable iff (reset_in)  // see [R14]
    wr_div |=> baud_div_r == $past(reg_req_in.wdata))
    else $error("divider write not stored");

  AST_DIVIDER_RESET: assert property (@(posedge core_clk_in)  // see [R17]
    reset_in |=> baud_div_r == BAUD_DIV_RESET)
    else $error("divider not cleared by reset");

  COV_FRAME_SENT: cover property (@(posedge core_clk_in) disable iff (reset_in)
    frame_end && !tx_hold_full_r);

  COV_BACK_TO_BACK: cover property (@(posedge core_clk_in) disable iff (reset_in)
    load_queued);

  COV_BYTE_RECEIVED: cover property (@(posedge core_clk_in) disable iff (reset_in)
    rx_byte.valid && !rx_full_r);

  COV_OVERRUN: cover property (@(posedge core_clk_in) disable iff (reset_in)
    rx_byte.valid && rx_full_r);

  COV_WRITE_AT_FRAME_END: cover property (@(posedge core_clk_in) disable iff (reset_in)
    frame_end && wr_data && !tx_hold_full_r);

endmodule // debug_serial_uart

// >>> tb/serial_terminal.sv
`timescale 1ns/1ps
module serial_terminal #(
  parameter int BIT_CLKS = 12
) (
  input wire logic core_clk_in,       // master clock
  input wire logic line_from_dut_in,  // device transmit pin
  output logic line_to_dut_out        // device receive pin
);
  logic [7:0] rx_q[$];
  int first_high_width = 0;

  initial line_to_dut_out = 1'b1;

  task automatic send_byte(input logic [7:0] b, input logic stop_bit);
    logic [9:0] frame;
    frame = {stop_bit, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk_in) line_to_dut_out <= frame[i];
      repeat (BIT_CLKS - 1) @(posedge core_clk_in);
    end
    @(posedge core_clk_in) line_to_dut_out <= 1'b1;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // width of the first high data bit; the start bit may be cut by the free prescaler
  initial begin
    @(negedge line_from_dut_in);
    @(posedge line_from_dut_in);
    while (line_from_dut_in == 1'b1) begin
      @(posedge core_clk_in);
      #1;
      first_high_width++;
    end
  end

  // decode at mid-bit, LSB first, drop frames with a low stop
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge line_from_dut_in);
      repeat (BIT_CLKS / 2) @(posedge core_clk_in);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge core_clk_in);
        #1;
        b[i] = line_from_dut_in;
      end
      repeat (BIT_CLKS) @(posedge core_clk_in);
      #1;
      if (line_from_dut_in === 1'b1) rx_q.push_back(b);
    end
  end
endmodule // serial_terminal

// >>> tb/tb_debug_serial_uart.sv
`timescale 1ns/1ps
module tb_debug_serial_uart;
  import debug_serial_uart_pkg::*;
  localparam int BIT_CLKS = 12;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  reg_req_t req = '0;
  logic [15:0] rdata;
  logic tx_line;
  logic rx_line;
  logic tx_irq;
  logic rx_irq;
  int fails = 0;
  int check_count = 0;
  int tx_irqs = 0;
  int rx_irqs = 0;

  debug_serial_uart u_debug_serial_uart (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .reg_req_in(req),
    .reg_rdata_out(rdata),
    .serial_rx_in(rx_line),
    .serial_tx_out(tx_line),
    .transmit_start_irq_out(tx_irq),
    .receive_done_irq_out(rx_irq)
  );

  serial_terminal #(.BIT_CLKS(BIT_CLKS)) u_serial_terminal (
    .core_clk_in(core_clk_in),
    .line_from_dut_in(tx_line),
    .line_to_dut_out(rx_line)
  );

  initial begin
    forever #5 core_clk_in = ~core_clk_in;
  end

  always @(posedge core_clk_in) begin
    if (tx_irq === 1'b1) tx_irqs++;
    if (rx_irq === 1'b1) rx_irqs++;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk_in) req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge core_clk_in) req <= '0;
  endtask

  task automatic reg_rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge core_clk_in) req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
    @(posedge core_clk_in) req <= '0;
    @(posedge core_clk_in) d = rdata;
  endtask

  task automatic chk_rd(input string name, input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    reg_rd(a, d);
    check(name, d, exp);
  endtask

  // poll status with a bound so a stuck flag cannot hang the run
  task automatic wait_st(input logic [15:0] mask, input logic [15:0] val);
    logic [15:0] d;
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 200 && !hit; i++) begin
      reg_rd(ADDR_LINE_STATE, d);
      hit = ((d & mask) === val);
    end
    check("status wait", {15'h0000, hit}, 16'h0001);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge core_clk_in);
    fails++;
    wrap_up();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge core_clk_in);
    reset_in <= 1'b0;
    chk_rd("status reset", ADDR_LINE_STATE, 16'h0000);
    chk_rd("low reset", ADDR_BYTE_LOW, 16'h0000);
    chk_rd("high reset", ADDR_BYTE_HIGH, 16'h0000);
    chk_rd("divider reset", ADDR_BAUD_DIV, 16'h0000);
    chk_rd("unmapped", 16'hC02C, 16'h0000);
    reg_wr(ADDR_LINE_STATE, 16'h000F);
    chk_rd("status ro", ADDR_LINE_STATE, 16'h0000);
    // prescale 1, bit time 6: twelve clocks a bit
    reg_wr(ADDR_BAUD_DIV, 16'h0106);
    chk_rd("divider", ADDR_BAUD_DIV, 16'h0106);
    $display("test registers done");

    reg_wr(ADDR_BYTE_LOW, 16'hAB55);
    chk_rd("status idle write", ADDR_LINE_STATE, 16'h0001);
    reg_wr(ADDR_BYTE_HIGH, 16'h3C99);
    chk_rd("status queued", ADDR_LINE_STATE, 16'h0003);
    wait_st(16'h0002, 16'h0000);
    chk_rd("status after hand-over", ADDR_LINE_STATE, 16'h0001);
    wait_st(16'h0001, 16'h0000);
    repeat (20) @(posedge core_clk_in);
    check("tx frames", 16'(u_serial_terminal.rx_q.size()), 16'h0002);
    check("tx byte 0", {8'h00, u_serial_terminal.rx_q[0]}, 16'h0055);
    check("tx byte 1", {8'h00, u_serial_terminal.rx_q[1]}, 16'h003C);
    check("bit clocks", 16'(u_serial_terminal.first_high_width), 16'(BIT_CLKS));
    check("tx irqs", 16'(tx_irqs), 16'h0002);
    $display("test transmit done");

    u_serial_terminal.send_byte(8'hA7, 1'b1);
    repeat (10) @(posedge core_clk_in);
    check("rx irqs 1", 16'(rx_irqs), 16'h0001);
    chk_rd("status full", ADDR_LINE_STATE, 16'h0004);
    u_serial_terminal.send_byte(8'h3E, 1'b1);
    repeat (10) @(posedge core_clk_in);
    chk_rd("status overrun", ADDR_LINE_STATE, 16'h000C);
    chk_rd("low data", ADDR_BYTE_LOW, 16'h003E);
    chk_rd("status read clear", ADDR_LINE_STATE, 16'h0008);
    u_serial_terminal.send_byte(8'h81, 1'b1);
    repeat (10) @(posedge core_clk_in);
    chk_rd("status no overrun", ADDR_LINE_STATE, 16'h0004);
    u_serial_terminal.send_byte(8'h12, 1'b0);
    repeat (10) @(posedge core_clk_in);
    check("rx irqs bad stop", 16'(rx_irqs), 16'h0003);
    chk_rd("status bad stop", ADDR_LINE_STATE, 16'h0004);
    chk_rd("high data", ADDR_BYTE_HIGH, 16'h8100);
    chk_rd("status high clear", ADDR_LINE_STATE, 16'h0000);
    // prescale 0, bit time 12: same rate through a faster sampling clock must still decode
    reg_wr(ADDR_BAUD_DIV, 16'h000C);
    u_serial_terminal.send_byte(8'hC3, 1'b1);
    repeat (10) @(posedge core_clk_in);
    check("rx irqs new divider", 16'(rx_irqs), 16'h0004);
    chk_rd("low data new divider", ADDR_BYTE_LOW, 16'h00C3);
    $display("test receive done");
    wrap_up();
  end
endmodule // tb_debug_serial_uart
